// ==== include/tbs_map.svh ====
// constants of the tape boot streamer: timing, framing, characters
// assumes the system clock runs at 50 MHz
`ifndef TBS_MAP_SVH
`define TBS_MAP_SVH
`define TBS_CLK_HZ       32'h02fa_f080
`define TBS_CLK_NS       32'h0000_0014
`define TBS_SETTLE_NS    32'h3b9a_ca00
`define TBS_SETTLE_CYC   (`TBS_SETTLE_NS / `TBS_CLK_NS)
`define TBS_BAUD_BASE    32'h0000_2580
`define TBS_BIT_CYC_BASE (`TBS_CLK_HZ / `TBS_BAUD_BASE)
`define TBS_FRAME_BITS   8'h0a
`define TBS_DIGIT_FRAMES 8'h01
`define TBS_CTRL_FRAMES  8'h0f
`define TBS_BREAK_FRAMES 8'h02
`define TBS_TERM_CHAR    8'h67
`define TBS_DIGIT_LO     8'h30
`define TBS_DIGIT_HI     8'h37
`define TBS_MARK         1'b1
`define TBS_SPACE        1'b0
`endif

// ==== include/tbs_pkg.sv ====
// types of the tape boot streamer
// assumes nothing of its surroundings
package tbs_pkg;
    typedef enum logic [6:0] {
        TBS_IDLE   = 7'h01,
        TBS_SETTLE = 7'h02,
        TBS_SEEK   = 7'h04,
        TBS_BREAK  = 7'h08,
        TBS_LOAD   = 7'h10,
        TBS_SEND   = 7'h20,
        TBS_PACE   = 7'h40
    } tbs_state_t;

    typedef enum logic [1:0] {
        TBS_B9600  = 2'h0,
        TBS_B19200 = 2'h1,
        TBS_B38400 = 2'h2
    } tbs_baud_t;

    // bit period and bit count of the interval being timed
    typedef struct packed {
        logic [15:0] period;
        logic [7:0]  bits;
    } tbs_pace_t;
endpackage : tbs_pkg

// ==== design/tbs_streamer.sv ====
// tape boot streamer: boot switch watch, settle wait, seek, break,
// paced serial transmission of tape characters to the host console
// assumes tape bytes arrive with valid/ready after the seek completes
`timescale 1ns/1ps
`include "tbs_map.svh"

// ============================================================
// fifo between tape read channel and transmitter
module tbs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_srst,
    input  wire logic             i_flush,
    // fill side
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    // drain side
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    logic             ready_reg;
    wire              push = i_in_valid & ready_reg;
    wire              pop  = i_out_ready & (count_reg != '0);

    assign count_next  = count_reg + {{AW{1'b0}}, push}
                         - {{AW{1'b0}}, pop};
    assign o_in_ready  = ready_reg;
    assign o_out_valid = count_reg != '0;
    assign o_out_data  = mem_reg[rd_ptr_reg];

    always_ff @(posedge i_clk) begin
        if (i_srst || i_flush) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
            ready_reg  <= 1'b0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + AW'(push);
            rd_ptr_reg <= rd_ptr_reg + AW'(pop);
            count_reg  <= count_next;
            // registered ready: full is seen one cycle ahead
            ready_reg  <= count_next != (AW+1)'(DEPTH);
        end
    end

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= i_in_data;
        end
    end
endmodule : tbs_fifo

// ============================================================
// top of the streamer
// Overview of operation
// (R1) at power-up a closed boot switch starts boot after one second
// (R2) in idle an open-then-close of the switch starts boot after one second
// (R3) boot seeks drive 0 block 0, then sends break, then tape characters
// (R4) after an octal digit character wait one 9600 baud character time
// (R5) after any other character wait fifteen character times
// (R6) after sending the terminating letter G return to idle
// (R7) boot runs only at 9600, 19200 or 38400 baud
// (R8) boot input is active when grounded by the closed switch
// (R9) break holds the line spacing longer than one character frame
// (R10) a character time is ten bits: start, eight data, one stop
module tbs_streamer #(
    parameter int SETTLE_CYC = `TBS_SETTLE_CYC,
    parameter int BIT_CYC    = `TBS_BIT_CYC_BASE
) (
    // clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_srst,
    // boot switch and line rate
    input  wire logic       i_boot_request_pin_n,
    input  wire logic [1:0] i_baud_sel,
    // tape positioning
    output logic            o_seek_req,
    input  wire logic       i_seek_done,
    // tape characters
    input  wire logic       i_tape_valid,
    input  wire logic [7:0] i_tape_data,
    output logic            o_tape_ready,
    // host serial line and status
    output logic            o_txd,
    output logic            o_boot_active
);
    // ========================================================
    // functions
    function automatic logic is_digit(input logic [7:0] c);
        return (c >= `TBS_DIGIT_LO) && (c <= `TBS_DIGIT_HI);
    endfunction : is_digit

    function automatic logic [15:0] bit_period(input logic [1:0] s);
        logic [15:0] base;
        base = 16'(BIT_CYC);
        unique case (tbs_pkg::tbs_baud_t'(s))
            tbs_pkg::TBS_B19200: return base >> 1;
            tbs_pkg::TBS_B38400: return base >> 2;
            default:             return base; // [R7]
        endcase
    endfunction : bit_period

    // ========================================================
    // state and registers
    tbs_pkg::tbs_state_t state_reg;
    tbs_pkg::tbs_state_t state_next;
    tbs_pkg::tbs_pace_t  pace_reg;
    tbs_pkg::tbs_pace_t  pace_next;
    logic [31:0] settle_cnt_reg;
    logic [15:0] div_cnt_reg;
    logic [7:0]  bit_cnt_reg;
    logic [8:0]  shift_reg;
    logic [7:0]  char_reg;
    logic        txd_reg;
    logic        seek_reg;
    logic        active_reg;
    logic        pwrup_reg;
    logic        open_reg;
    logic        fifo_valid;
    logic [7:0]  fifo_data;
    logic        fifo_ready;

    // ========================================================
    // decode
    wire st_idle   = state_reg == tbs_pkg::TBS_IDLE;
    wire st_settle = state_reg == tbs_pkg::TBS_SETTLE;
    wire st_seek   = state_reg == tbs_pkg::TBS_SEEK;
    wire st_break  = state_reg == tbs_pkg::TBS_BREAK;
    wire st_load   = state_reg == tbs_pkg::TBS_LOAD;
    wire st_send   = state_reg == tbs_pkg::TBS_SEND;
    wire st_pace   = state_reg == tbs_pkg::TBS_PACE;
    wire sw_closed = ~i_boot_request_pin_n; // [R8]
    wire start_boot = st_idle & sw_closed & (pwrup_reg | open_reg); // [R1] [R2]
    wire settle_end = st_settle
                      & (settle_cnt_reg == 32'(SETTLE_CYC - 1));
    wire tick       = div_cnt_reg == pace_reg.period - 16'h0001;
    wire last_bit   = tick & (bit_cnt_reg == pace_reg.bits - 8'h01);
    wire frame_end  = st_send & last_bit;
    wire take_char  = st_load & fifo_valid;
    wire term_sent  = frame_end & (char_reg == `TBS_TERM_CHAR); // [R6]
    wire [15:0] line_period = bit_period(i_baud_sel);
    wire [7:0]  ctrl_bits   = 8'(`TBS_CTRL_FRAMES * `TBS_FRAME_BITS);
    wire [7:0]  brk_bits    = 8'(`TBS_BREAK_FRAMES * `TBS_FRAME_BITS);
    wire [7:0]  dig_bits    = 8'(`TBS_DIGIT_FRAMES * `TBS_FRAME_BITS);

    // ========================================================
    // sequencer
    always_comb begin
        state_next = state_reg;
        pace_next  = pace_reg;
        unique case (state_reg)
            tbs_pkg::TBS_IDLE:
                if (start_boot) state_next = tbs_pkg::TBS_SETTLE;
            tbs_pkg::TBS_SETTLE:
                if (settle_end) state_next = tbs_pkg::TBS_SEEK;
            tbs_pkg::TBS_SEEK: begin
                if (i_seek_done) begin // [R3]
                    state_next = tbs_pkg::TBS_BREAK;
                    pace_next  = '{period: line_period, bits: brk_bits}; // [R9]
                end
            end
            tbs_pkg::TBS_BREAK: begin
                if (last_bit) begin
                    // one frame of marking before the first character
                    state_next = tbs_pkg::TBS_PACE;
                    pace_next.bits = `TBS_FRAME_BITS;
                end
            end
            tbs_pkg::TBS_LOAD: begin
                if (fifo_valid) begin
                    state_next = tbs_pkg::TBS_SEND;
                    pace_next  = '{period: line_period,
                                   bits: `TBS_FRAME_BITS}; // [R10]
                end
            end
            tbs_pkg::TBS_SEND: begin
                if (term_sent) begin
                    state_next = tbs_pkg::TBS_IDLE;
                end else if (frame_end && is_digit(char_reg)) begin
                    state_next = tbs_pkg::TBS_PACE;
                    pace_next  = '{period: 16'(BIT_CYC), bits: dig_bits}; // [R4]
                end else if (frame_end) begin
                    state_next = tbs_pkg::TBS_PACE;
                    pace_next.bits = ctrl_bits; // [R5]
                end
            end
            tbs_pkg::TBS_PACE:
                if (last_bit) state_next = tbs_pkg::TBS_LOAD;
            default: state_next = tbs_pkg::TBS_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            state_reg <= tbs_pkg::TBS_IDLE;
            pace_reg  <= '{period: 16'h0001, bits: 8'h01};
        end else begin
            state_reg <= state_next;
            pace_reg  <= pace_next;
        end
    end

    // ========================================================
    // switch watch and settle timer
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            pwrup_reg      <= 1'b1;
            open_reg       <= 1'b0;
            settle_cnt_reg <= 32'h0000_0000;
        end else begin
            if (st_idle) pwrup_reg <= 1'b0; // [R1]
            if (!st_idle) open_reg <= 1'b0;
            else if (!sw_closed) open_reg <= 1'b1; // [R2]
            settle_cnt_reg <= st_settle ? settle_cnt_reg + 32'h0000_0001
                                        : 32'h0000_0000;
        end
    end

    // ========================================================
    // bit timer
    always_ff @(posedge i_sys_clk) begin
        if (i_srst || state_next != state_reg) begin
            div_cnt_reg <= 16'h0000;
            bit_cnt_reg <= 8'h00;
        end else if (tick) begin
            div_cnt_reg <= 16'h0000;
            bit_cnt_reg <= bit_cnt_reg + 8'h01;
        end else begin
            div_cnt_reg <= div_cnt_reg + 16'h0001;
        end
    end

    // ========================================================
    // transmitter and outputs
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            txd_reg    <= `TBS_MARK;
            shift_reg  <= 9'h000;
            char_reg   <= 8'h00;
            seek_reg   <= 1'b0;
            active_reg <= 1'b0;
        end else begin
            seek_reg   <= settle_end | (st_seek & ~i_seek_done);
            active_reg <= state_next != tbs_pkg::TBS_IDLE;
            if (st_seek && i_seek_done) begin
                txd_reg <= `TBS_SPACE; // [R9]
            end else if (st_break && last_bit) begin
                txd_reg <= `TBS_MARK;
            end else if (take_char) begin
                txd_reg   <= `TBS_SPACE;
                shift_reg <= {`TBS_MARK, fifo_data};
                char_reg  <= fifo_data;
            end else if (st_send && tick && !last_bit) begin
                txd_reg   <= shift_reg[0]; // [R10]
                shift_reg <= {`TBS_MARK, shift_reg[8:1]};
            end
        end
    end

    assign o_txd         = txd_reg;
    assign o_seek_req    = seek_reg;
    assign o_boot_active = active_reg;

    tbs_fifo #(
        .WIDTH (8),
        .DEPTH (16)
    ) u_fifo (
        .i_clk       (i_sys_clk),
        .i_srst      (i_srst),
        .i_flush     (st_idle | st_settle),
        .i_in_valid  (i_tape_valid),
        .i_in_data   (i_tape_data),
        .o_in_ready  (fifo_ready),
        .o_out_valid (fifo_valid),
        .o_out_data  (fifo_data),
        .i_out_ready (st_load)
    );
    assign o_tape_ready = fifo_ready;

    // ========================================================
    // checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);

    logic [31:0] hlp_len_reg;
    always_ff @(posedge i_sys_clk) begin
        hlp_len_reg <= (st_settle || st_break) ? hlp_len_reg + 32'h0000_0001
                                               : 32'h0000_0000;
    end

    AST_PWRUP_CLOSED: assert property ( // [R1]
        st_idle && pwrup_reg && !i_boot_request_pin_n |=> st_settle)
        else $error("closed switch at power-up did not start settle");
    AST_SETTLE_LEN: assert property ( // [R2]
        $fell(st_settle) |-> $past(hlp_len_reg) == 32'(SETTLE_CYC - 1))
        else $error("settle wait length wrong");
    AST_NO_REOPEN: assert property ( // [R2]
        st_idle && !pwrup_reg && !open_reg |=> !st_settle)
        else $error("boot started without open-then-close");
    AST_SEEK_BEFORE_BREAK: assert property ( // [R3]
        st_seek |-> o_txd ##1 (st_seek || st_break))
        else $error("line left marking during seek");
    AST_BREAK_SPACE: assert property ( // [R9]
        $fell(st_break) |-> !$past(o_txd) && $past(hlp_len_reg)
            >= 32'(`TBS_FRAME_BITS) * 32'(pace_reg.period))
        else $error("break too short or not spacing");
    AST_DIGIT_PACE: assert property ( // [R4]
        frame_end && is_digit(char_reg) |=> st_pace
            && pace_reg.bits == `TBS_FRAME_BITS
            && pace_reg.period == 16'(BIT_CYC))
        else $error("digit pacing wrong");
    AST_CTRL_PACE: assert property ( // [R5]
        frame_end && !is_digit(char_reg) && char_reg != `TBS_TERM_CHAR
            |=> st_pace && pace_reg.bits == 8'h96)
        else $error("control pacing wrong");
    AST_TERM_IDLE: assert property ( // [R6]
        term_sent |=> st_idle ##1 !o_boot_active)
        else $error("did not leave boot after terminator");
    AST_START_BIT: assert property ( // [R10]
        take_char |=> !o_txd [*2] ##0 st_send)
        else $error("start bit missing");
    AST_PACE_MARK: assert property ( // [R4]
        st_pace |-> o_txd)
        else $error("line not marking while pacing");

    COV_BOOT_DONE: cover property (term_sent ##1 st_idle);
    COV_DIGIT: cover property (frame_end && is_digit(char_reg));
    COV_CTRL: cover property (frame_end && !is_digit(char_reg));
    COV_REBOOT: cover property (st_idle && open_reg && sw_closed);
endmodule : tbs_streamer

// ==== tb/tbs_host_rx.sv ====
// host console line model: receives frames, measures break length
// assumes one clock; line sampled near mid-bit on falling clock edges
`timescale 1ns/1ps

// ============================================================
// host serial receiver
module tbs_host_rx (
    // clock and line
    input  wire logic i_clk,
    input  wire logic i_rxd,
    // bit period in clocks, 9600/19200/38400 rates only
    input  wire logic [31:0] i_bit_cyc,
    // length of the last break
    output int        o_brk_cyc
);
    logic [7:0] sh;
    logic [7:0] rx_q[$];
    int         t_q[$];
    int         cyc = 0;
    int         t0;

    always @(posedge i_clk) begin
        cyc <= cyc + 1;
    end

    // start, eight data lsb first, stop; low stop means break
    initial begin
        o_brk_cyc = 0;
        forever begin
            @(negedge i_clk iff i_rxd === 1'b0);
            t0 = cyc;
            repeat (i_bit_cyc / 2) @(negedge i_clk);
            for (int i = 0; i < 8; i++) begin
                repeat (i_bit_cyc) @(negedge i_clk);
                sh[i] = i_rxd;
            end
            repeat (i_bit_cyc) @(negedge i_clk);
            if (i_rxd === 1'b1) begin
                rx_q.push_back(sh);
                t_q.push_back(t0);
            end else begin
                while (i_rxd !== 1'b1) @(negedge i_clk);
                o_brk_cyc = cyc - t0;
            end
        end
    end
endmodule : tbs_host_rx

// ==== tb/tbs_streamer_bench.sv ====
// self-checking bench of the tape boot streamer
// assumes short settle and bit counts set by the parameters below
`timescale 1ns/1ps

// ============================================================
// bench top
module tbs_streamer_bench;
    localparam int SC = 100;
    localparam int BC = 16;

    logic       clk;
    logic       srst;
    logic       pin_n;
    logic [1:0] baud_sel;
    logic       seek_req;
    logic       seek_done;
    logic       tape_valid;
    logic [7:0] tape_data;
    logic       tape_ready;
    logic       txd;
    logic       boot_active;
    int         pbit;
    int         brk_cyc;
    int         miscompares = 0;
    int         checks_done = 0;

    tbs_streamer #(.SETTLE_CYC(SC), .BIT_CYC(BC)) DUT (
        .i_sys_clk           (clk),
        .i_srst              (srst),
        .i_boot_request_pin_n(pin_n),
        .i_baud_sel          (baud_sel),
        .o_seek_req          (seek_req),
        .i_seek_done         (seek_done),
        .i_tape_valid        (tape_valid),
        .i_tape_data         (tape_data),
        .o_tape_ready        (tape_ready),
        .o_txd               (txd),
        .o_boot_active       (boot_active)
    );

    tbs_host_rx host (
        .i_clk    (clk),
        .i_rxd    (txd),
        .i_bit_cyc(pbit),
        .o_brk_cyc(brk_cyc)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ========================================================
    // compare and report
    task check(input string nm, input logic [31:0] seen,
               input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : check

    task near(input string nm, input int seen, input int exp);
        check(nm, (seen >= exp) && (seen <= exp + 4), 1'b1);
    endtask : near

    task test_done;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    task fail_out(input string nm);
        check(nm, 1'b0, 1'b1);
        test_done();
    endtask : fail_out

    // ========================================================
    // one boot: settle, seek, break, stream, back to idle
    task boot_run(input string s, output int st);
        int   n;
        int   k;
        int   gap;
        int   tf;
        logic dig;
        #1;
        pbit = BC >> baud_sel;
        n = 0;
        while (seek_req !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
            if (n == 3) check("active", boot_active, 1'b1);
            if (txd !== 1'b1 || n > SC + 9) fail_out("settle");
        end
        check("settle_len", n, SC + 1);
        @(posedge clk) seek_done <= 1'b1;
        @(posedge clk) seek_done <= 1'b0;
        #1;
        check("seek_drop", seek_req, 1'b0);
        check("break_on", txd, 1'b0);
        st = 0;
        for (int i = 0; i < s.len(); i++) begin
            @(posedge clk) begin
                tape_valid <= 1'b1;
                tape_data  <= s[i];
            end
            @(negedge clk);
            while (tape_ready !== 1'b1) begin
                @(negedge clk);
                st++;
                if (st > 30000) fail_out("feed");
            end
            @(posedge clk) tape_valid <= 1'b0;
        end
        k = 0;
        while (boot_active !== 1'b0) begin
            @(negedge clk);
            k++;
            if (k > 30000) fail_out("idle");
        end
        tf = host.cyc;
        k = 0;
        while (s[k] != 8'h67) k++;
        check("count", host.rx_q.size(), k + 1);
        for (int i = 0; i <= k && i < host.rx_q.size(); i++) begin
            check("char", host.rx_q[i], s[i]);
            if (i > 0) begin
                dig = (s[i-1] >= 8'h30) && (s[i-1] <= 8'h37);
                gap = host.t_q[i] - host.t_q[i-1];
                if (dig) near("dgap", gap, 10 * pbit + 10 * BC);
                else near("cgap", gap, 160 * pbit);
            end
        end
        near("term_idle", tf - host.t_q[$], 10 * pbit);
        check("break_len", brk_cyc, 20 * pbit);
        host.rx_q.delete();
        host.t_q.delete();
    endtask : boot_run

    // ========================================================
    // scenarios
    task test_powerup;
        int st;
        boot_run("0123456701234567/8AgZ", st);
        check("fifo_full", st > 0, 1'b1);
        $display("test powerup done");
    endtask : test_powerup

    task test_held;
        logic seen;
        seen = 1'b0;
        repeat (3 * SC) begin
            @(negedge clk);
            seen = seen | boot_active;
        end
        check("held", seen, 1'b0);
        @(posedge clk) pin_n <= 1'b1;
        repeat (3 * SC) begin
            @(negedge clk);
            seen = seen | boot_active;
        end
        check("open", seen, 1'b0);
        $display("test held done");
    endtask : test_held

    task test_switch(input logic [1:0] sel, input string s);
        int st;
        @(posedge clk) pin_n <= 1'b1;
        repeat (5) @(posedge clk);
        @(posedge clk) begin
            pin_n    <= 1'b0;
            baud_sel <= sel;
        end
        boot_run(s, st);
        $display("test switch done");
    endtask : test_switch

    initial begin
        srst       = 1'b1;
        pin_n      = 1'b0;
        baud_sel   = 2'h0;
        seek_done  = 1'b0;
        tape_valid = 1'b0;
        tape_data  = 8'h00;
        pbit       = BC;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        test_powerup();
        test_held();
        test_switch(2'h2, "5Ag");
        test_switch(2'h1, "7\rgZ");
        test_done();
    end
endmodule : tbs_streamer_bench
